// ---- logic/tmr_pkg.sv ----
// Purpose: shared constants and types for the trigger timer
// Assumes: mclk stands for the high-frequency clock
// Notes: field layout follows the control byte, bit 7 down to bit 0
package tmr_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] DATA_RESET = 16'hFFFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam int PRE_W = 11;
    localparam int DIV_SLOW_LOG2 = 11;
    localparam int DIV_MID_LOG2 = 7;
    localparam int DIV_FAST_LOG2 = 3;
    localparam int LF_DIV_LOG2 = 3;
    // noise limit in high-clock periods, and mclk cycles per such period
    localparam int NOISE_REJECT_HF = 4;
    localparam int MCLK_PER_HF = 1;
    localparam int FILTER_CYCLES = NOISE_REJECT_HF * MCLK_PER_HF + 1;

    typedef enum logic [1:0] {
        START_STOP = 2'h0,
        START_CMD = 2'h1,
        START_RISE = 2'h2,
        START_FALL = 2'h3
    } start_type;

    typedef enum logic [1:0] {
        CK_DIV_SLOW = 2'h0,
        CK_DIV_MID = 2'h1,
        CK_DIV_FAST = 2'h2,
        CK_EXT_PIN = 2'h3
    } clk_sel_type;

    typedef enum logic [1:0] {
        MODE_TIMER = 2'h0,
        MODE_WINDOW = 2'h1,
        MODE_PULSE = 2'h2,
        MODE_PPG = 2'h3
    } mode_type;

    typedef struct packed {
        logic output_flipflop_control;
        logic opt;
        start_type start_control_field;
        clk_sel_type source_clock_select;
        mode_type operating_mode_select;
    } ctrl_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_COUNT = 3'h4
    } state_type;
endpackage

// ---- logic/trig_noise_filter.sv ----
// Purpose: noise rejection on the trigger input
// Assumes: input already synchronous to mclk
// Notes: a level is accepted only after it stays for STABLE_CYCLES
`timescale 1ns/100ps
module trig_noise_filter
    import tmr_pkg::*;
#(
    parameter int STABLE_CYCLES = FILTER_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic raw_in,
    input wire logic bypass,
    output logic level_out
);
    localparam int RUN_W = $clog2(STABLE_CYCLES + 1);

    logic level_ff;
    logic nxt_level;
    logic [RUN_W-1:0] run_ff;
    logic [RUN_W-1:0] nxt_run;

    if (STABLE_CYCLES < 2) begin : g_len_check
        $error("STABLE_CYCLES must be at least 2");
    end

    always_comb begin
        nxt_level = level_ff;
        nxt_run = '0;
        if (bypass) begin
            nxt_level = raw_in; // [RULE23]
        end else if (raw_in != level_ff) begin
            nxt_run = run_ff + RUN_W'(1);
            if (run_ff == RUN_W'(STABLE_CYCLES - 1)) begin
                nxt_level = raw_in; // [RULE21]
                nxt_run = '0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            level_ff <= 1'b0;
            run_ff <= '0;
        end else begin
            level_ff <= nxt_level;
            run_ff <= nxt_run;
        end
    end

    assign level_out = level_ff;

    a_short_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        (!bypass && $changed(level_ff)) |->
        $past(raw_in, 2) == level_ff) // [RULE21]
        else $error("filter passed a pulse that was too short");
endmodule // trig_noise_filter

// ---- logic/trig_timer.sv ----
// Purpose: 16-bit up-counting timer, timer and external trigger modes
// Assumes: mclk is the high clock; all inputs synchronous to mclk
// Notes: window, pulse width and pulse-output modes hold idle
//
// How it works
// (RULE1) compare/capture writes are staged, applied on first source tick
// (RULE2) a lower-byte write alone never changes the live register
// (RULE3) software writes lower byte first, then upper byte
// (RULE4) software changes mode and clock only while start field is 00
// (RULE5) software uses auto-capture only in timer, event and window modes
// (RULE6) software keeps compare above 1, and above second register in PPG
// (RULE7) software keeps output flip-flop control 0 outside PPG mode
// (RULE8) software writes second register only after selecting PPG mode
// (RULE9) stop power mode forces start field to 00 and halts counting
// (RULE10) auto-capture copies counter each source tick; wait one tick to read
// (RULE11) software reads captures only while running with capture enabled
// (RULE12) six modes exist; this block runs timer and external trigger
// (RULE13) timer mode counts source ticks; on match irq, clear, continue
// (RULE14) timer mode with auto-capture loads counter into second register
// (RULE15) trigger mode waits for selected pin edge, then counts ticks
// (RULE16) trigger mode match clears and halts counter and raises irq
// (RULE17) stop option 1: opposite edge before match clears, halts, no irq
// (RULE18) after halt, next trigger edge restarts counting from zero
// (RULE19) stop option 0: opposite edges are ignored while counting
// (RULE20) stop option 0: new trigger edges ignored while counting
// (RULE21) trigger pulses of four high-clock periods or less are dropped
// (RULE22) source holds each trigger level twelve high-clock periods
// (RULE23) filter bypassed in slow and sleep modes; this block has no sleep input, bypass follows slow_mode only
// (RULE24) clock select: 00 /2^11 or slow/2^3, 01 /2^7, 10 /2^3, 11 pin
// (RULE25) mode select: 00 timer, 01 window, 10 pulse width, 11 pulse output
// (RULE26) start field: 00 stop and clear, 01 command, 10 rise, 11 fall
// (RULE27) registers are 16 bits; match irq is a one-cycle pulse
`timescale 1ns/100ps
module trig_timer
    import tmr_pkg::*;
#(
    parameter int FILTER_LEN = FILTER_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic cmp_lo_wr,
    input wire logic cmp_hi_wr,
    input wire logic cap_lo_wr,
    input wire logic cap_hi_wr,
    input wire logic [7:0] wr_byte,
    input wire logic stop_mode,
    input wire logic slow_mode,
    input wire logic prescaler_tap_select,
    input wire logic low_freq_clock,
    input wire logic trigger_input_pin,
    output ctrl_type timer_control_reg,
    output logic [CNT_W-1:0] compare_value_reg,
    output logic [CNT_W-1:0] capture_second_reg,
    output logic [CNT_W-1:0] count_value,
    output logic match_interrupt
);
    if (FILTER_LEN < 2) begin : g_len_check
        $error("FILTER_LEN must be at least 2");
    end

    // prescaler and source tick
    logic [PRE_W-1:0] pre_ff;
    logic [PRE_W-1:0] nxt_pre;
    logic [LF_DIV_LOG2-1:0] lf_div_ff;
    logic [LF_DIV_LOG2-1:0] nxt_lf_div;
    logic lf_prev_ff;
    logic lf_tick;
    logic src_tick;
    logic trig_lvl;
    logic trig_prev_ff;
    logic trig_rise;
    logic trig_fall;

    ctrl_type ctrl_ff;
    ctrl_type nxt_ctrl;

    trig_noise_filter #(
        .STABLE_CYCLES(FILTER_LEN)
    ) u_filter (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .raw_in(trigger_input_pin),
        .bypass(slow_mode),
        .level_out(trig_lvl)
    );

    assign trig_rise = trig_lvl && !trig_prev_ff;
    assign trig_fall = !trig_lvl && trig_prev_ff;
    assign lf_tick = low_freq_clock && !lf_prev_ff &&
                     (&lf_div_ff);

    always_comb begin
        nxt_pre = pre_ff + PRE_W'(1);
        nxt_lf_div = lf_div_ff;
        if (low_freq_clock && !lf_prev_ff) begin
            nxt_lf_div = lf_div_ff + LF_DIV_LOG2'(1);
        end
        case (ctrl_ff.source_clock_select) // [RULE24]
            CK_DIV_SLOW: begin
                if (slow_mode || prescaler_tap_select) begin
                    src_tick = lf_tick;
                end else begin
                    src_tick = &pre_ff[DIV_SLOW_LOG2-1:0];
                end
            end
            CK_DIV_MID: src_tick = &pre_ff[DIV_MID_LOG2-1:0];
            CK_DIV_FAST: src_tick = &pre_ff[DIV_FAST_LOG2-1:0];
            CK_EXT_PIN: src_tick = trig_rise;
            default: src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pre_ff <= '0;
            lf_div_ff <= '0;
            lf_prev_ff <= 1'b0;
            trig_prev_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            lf_div_ff <= nxt_lf_div;
            lf_prev_ff <= low_freq_clock;
            trig_prev_ff <= trig_lvl;
        end
    end

    // counter state machine
    state_type state_ff;
    state_type nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic irq_ff;
    logic nxt_irq;
    logic [CNT_W-1:0] cmp_ff;
    logic timer_run;
    logic ext_run;
    logic halted;
    logic match_now;
    logic trig_edge;
    logic opp_edge;
    logic cap_load;

    assign halted = (ctrl_ff.start_control_field == START_STOP) || stop_mode;
    assign timer_run = (ctrl_ff.operating_mode_select == MODE_TIMER) &&
                       (ctrl_ff.start_control_field == START_CMD); // [RULE25]
    assign ext_run = (ctrl_ff.operating_mode_select == MODE_TIMER) &&
                     ctrl_ff.start_control_field[1]; // [RULE12]
    assign trig_edge = (ctrl_ff.start_control_field == START_RISE) ?
                       trig_rise : trig_fall;
    assign opp_edge = (ctrl_ff.start_control_field == START_RISE) ?
                      trig_fall : trig_rise;
    assign match_now = src_tick && (state_ff == ST_COUNT) &&
                       ((cnt_ff + CNT_ONE) == cmp_ff);
    assign cap_load = timer_run && ctrl_ff.opt &&
                      (state_ff == ST_COUNT) && src_tick; // [RULE10]

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_irq = 1'b0;
        if (halted) begin
            nxt_state = ST_IDLE; // [RULE26] [RULE9]
            nxt_cnt = CNT_ZERO;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (timer_run) begin
                        nxt_state = ST_COUNT;
                    end else if (ext_run) begin
                        nxt_state = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!ext_run) begin
                        nxt_state = ST_IDLE;
                    end else if (trig_edge) begin
                        nxt_state = ST_COUNT; // [RULE15] [RULE18]
                        nxt_cnt = CNT_ZERO;
                    end
                end
                ST_COUNT: begin
                    if (!timer_run && !ext_run) begin
                        nxt_state = ST_IDLE;
                        nxt_cnt = CNT_ZERO;
                    end else if (match_now) begin
                        nxt_cnt = CNT_ZERO; // [RULE13]
                        nxt_irq = 1'b1; // [RULE27]
                        if (ext_run) begin
                            nxt_state = ST_WAIT; // [RULE16]
                        end
                    end else if (ext_run && ctrl_ff.opt && opp_edge) begin
                        nxt_state = ST_WAIT; // [RULE17]
                        nxt_cnt = CNT_ZERO;
                    end else if (src_tick) begin
                        // edges here are ignored without stop option
                        nxt_cnt = cnt_ff + CNT_ONE; // [RULE19] [RULE20]
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_cnt = CNT_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= CNT_ZERO;
            irq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            irq_ff <= nxt_irq;
        end
    end

    // control and timer registers
    logic [CNT_W-1:0] nxt_cmp;
    logic [CNT_W-1:0] cap_ff;
    logic [CNT_W-1:0] nxt_cap;
    logic [CNT_W-1:0] cmp_stage_ff;
    logic [CNT_W-1:0] nxt_cmp_stage;
    logic [CNT_W-1:0] cap_stage_ff;
    logic [CNT_W-1:0] nxt_cap_stage;
    logic cmp_pend_ff;
    logic nxt_cmp_pend;
    logic cap_pend_ff;
    logic nxt_cap_pend;
    logic ppg_mode;

    assign ppg_mode = ctrl_ff.operating_mode_select == MODE_PPG;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_cmp = cmp_ff;
        nxt_cap = cap_ff;
        nxt_cmp_stage = cmp_stage_ff;
        nxt_cap_stage = cap_stage_ff;
        nxt_cmp_pend = cmp_pend_ff;
        nxt_cap_pend = cap_pend_ff;
        if (ctrl_wr) begin
            nxt_ctrl = ctrl_type'(ctrl_wdata);
        end
        if (stop_mode) begin
            nxt_ctrl.start_control_field = START_STOP; // [RULE9]
        end
        // apply on tick first; a same-cycle upper write re-arms the stage
        if (src_tick && cmp_pend_ff) begin
            nxt_cmp = cmp_stage_ff; // [RULE1]
            nxt_cmp_pend = 1'b0;
        end
        if (src_tick && cap_pend_ff) begin
            nxt_cap = cap_stage_ff; // [RULE1]
            nxt_cap_pend = 1'b0;
        end
        if (cap_load) begin
            nxt_cap = cnt_ff; // [RULE14]
        end
        if (cmp_lo_wr) begin
            nxt_cmp_stage[7:0] = wr_byte; // [RULE2]
        end
        if (cmp_hi_wr) begin
            nxt_cmp_stage[15:8] = wr_byte;
            nxt_cmp_pend = 1'b1;
        end
        if (cap_lo_wr && ppg_mode) begin
            nxt_cap_stage[7:0] = wr_byte;
        end
        if (cap_hi_wr && ppg_mode) begin
            nxt_cap_stage[15:8] = wr_byte;
            nxt_cap_pend = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_ff <= ctrl_type'(CTRL_RESET);
            cmp_ff <= DATA_RESET;
            cap_ff <= DATA_RESET;
            cmp_stage_ff <= DATA_RESET;
            cap_stage_ff <= DATA_RESET;
            cmp_pend_ff <= 1'b0;
            cap_pend_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            cmp_ff <= nxt_cmp;
            cap_ff <= nxt_cap;
            cmp_stage_ff <= nxt_cmp_stage;
            cap_stage_ff <= nxt_cap_stage;
            cmp_pend_ff <= nxt_cmp_pend;
            cap_pend_ff <= nxt_cap_pend;
        end
    end

    assign timer_control_reg = ctrl_ff;
    assign compare_value_reg = cmp_ff;
    assign capture_second_reg = cap_ff;
    assign count_value = cnt_ff;
    assign match_interrupt = irq_ff;

    a_stop_clears_count: assert property (@(posedge mclk) // [RULE26]
        disable iff (sys_rst)
        halted |=> (cnt_ff == CNT_ZERO) && (state_ff == ST_IDLE))
        else $error("stop did not clear and halt the counter");

    a_stop_mode_start: assert property (@(posedge mclk) // [RULE9]
        disable iff (sys_rst)
        stop_mode |=> ctrl_ff.start_control_field == START_STOP)
        else $error("stop power mode left start field set");

    a_lower_only_write: assert property (@(posedge mclk) // [RULE2]
        disable iff (sys_rst)
        (cmp_lo_wr && !cmp_hi_wr && !cmp_pend_ff) |=> $stable(cmp_ff))
        else $error("lower byte alone changed compare value");

    a_staged_apply: assert property (@(posedge mclk) // [RULE1]
        disable iff (sys_rst)
        (cmp_pend_ff && src_tick) |=> cmp_ff == $past(cmp_stage_ff))
        else $error("staged compare not applied on source tick");

    a_irq_one_cycle: assert property (@(posedge mclk) // [RULE27]
        disable iff (sys_rst)
        match_interrupt |=> !match_interrupt)
        else $error("match interrupt longer than one cycle");

    a_match_clears: assert property (@(posedge mclk) // [RULE13]
        disable iff (sys_rst)
        (match_now && !halted && (timer_run || ext_run)) |=>
        (cnt_ff == CNT_ZERO) && match_interrupt)
        else $error("match did not clear counter with interrupt");

    a_ext_match_halt: assert property (@(posedge mclk) // [RULE16]
        disable iff (sys_rst)
        (match_now && ext_run && !halted) |=> state_ff == ST_WAIT)
        else $error("trigger mode did not halt on match");

    a_opp_edge_stop: assert property (@(posedge mclk) // [RULE17]
        disable iff (sys_rst)
        (ext_run && ctrl_ff.opt && opp_edge && state_ff == ST_COUNT &&
         !match_now && !halted) |=>
        (state_ff == ST_WAIT) && !match_interrupt && (cnt_ff == CNT_ZERO))
        else $error("opposite edge did not stop the count quietly");

    a_no_retrigger: assert property (@(posedge mclk) // [RULE20]
        disable iff (sys_rst)
        (ext_run && !ctrl_ff.opt && trig_edge && !src_tick &&
         state_ff == ST_COUNT && !halted) |=> $stable(cnt_ff))
        else $error("trigger edge disturbed a running count");

    a_auto_capture: assert property (@(posedge mclk) // [RULE14]
        disable iff (sys_rst)
        cap_load |=> capture_second_reg == $past(cnt_ff))
        else $error("auto-capture missed the counter value");
endmodule // trig_timer

// ---- tb/pulse_source.sv ----
// Purpose: external pulse source on the trigger pin
// Assumes: driven from the bench by task calls
// Notes: glitch is meant only for noise-rejection scenarios
`timescale 1ns/100ps
module pulse_source (
    input wire logic mclk,
    output logic trigger_input_pin
);
    localparam int MIN_HOLD = 12;

    initial trigger_input_pin = 1'b0;

    // hold each level long enough for a guaranteed detection
    task automatic level(input logic lvl, input int hold);
        @(posedge mclk);
        trigger_input_pin <= lvl;
        repeat ((hold < MIN_HOLD) ? MIN_HOLD : hold)
            @(posedge mclk);
    endtask

    // short excursion, then back to the opposite level and held
    task automatic glitch(input logic lvl, input int width);
        @(posedge mclk);
        trigger_input_pin <= lvl;
        repeat (width) @(posedge mclk);
        trigger_input_pin <= ~lvl;
        repeat (MIN_HOLD) @(posedge mclk);
    endtask
endmodule // pulse_source

// ---- tb/trig_timer_bench.sv ----
// Purpose: self-checking bench for the trigger timer
// Assumes: a staged compare applies within a few source ticks
// Notes: clock code 10 (divide by 8) keeps most runs short
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module trig_timer_bench
    import tmr_pkg::*;
;
    logic mclk = 0, sys_rst = 1, ctrl_wr = 0, cmp_lo_wr = 0, cmp_hi_wr = 0;
    logic cap_lo_wr = 0, cap_hi_wr = 0, stop_mode = 0, slow_mode = 0;
    logic prescaler_tap_select = 0, low_freq_clock = 0;
    logic [7:0] ctrl_wdata = 0, wr_byte = 0;
    logic trigger_input_pin, match_interrupt;
    ctrl_type timer_control_reg;
    logic [15:0] compare_value_reg, capture_second_reg, count_value, prev;
    int n_mismatch = 0, cmp_count = 0, cycles = 0, lf_cnt = 0, n, k, t0;
    logic [7:0] ck [4] = '{8'h10, 8'h10, 8'h14, 8'h18};
    int per [4] = '{10240, 2000, 640, 40};

    always #12.5 mclk = ~mclk;

    // slow clock with a period of 50 mclk cycles
    always @(posedge mclk) begin
        lf_cnt <= (lf_cnt == 24) ? 0 : lf_cnt + 1;
        if (lf_cnt == 24)
            low_freq_clock <= ~low_freq_clock;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            stop_test();
        end
    end

    pulse_source i_src (.mclk(mclk), .trigger_input_pin(trigger_input_pin));

    trig_timer i_dut (.mclk(mclk), .sys_rst(sys_rst), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .cmp_lo_wr(cmp_lo_wr),
        .cmp_hi_wr(cmp_hi_wr), .cap_lo_wr(cap_lo_wr),
        .cap_hi_wr(cap_hi_wr), .wr_byte(wr_byte), .stop_mode(stop_mode),
        .slow_mode(slow_mode), .prescaler_tap_select(prescaler_tap_select),
        .low_freq_clock(low_freq_clock),
        .trigger_input_pin(trigger_input_pin),
        .timer_control_reg(timer_control_reg),
        .compare_value_reg(compare_value_reg),
        .capture_second_reg(capture_second_reg),
        .count_value(count_value), .match_interrupt(match_interrupt));

    task stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task cyc(input int c);
        repeat (c) begin
            @(posedge mclk);
            #1;
        end
    endtask

    task wr_ctrl(input logic [7:0] v);
        @(posedge mclk);
        ctrl_wr <= 1;
        ctrl_wdata <= v;
        @(posedge mclk);
        ctrl_wr <= 0;
        #1;
        `CHK("control", v, timer_control_reg)
    endtask

    // lower byte, then upper byte on the next edge
    task wr16(input logic cap, input logic [15:0] v);
        @(posedge mclk);
        {cap_lo_wr, cmp_lo_wr} <= cap ? 2'b10 : 2'b01;
        wr_byte <= v[7:0];
        @(posedge mclk);
        {cap_lo_wr, cmp_lo_wr} <= 2'b00;
        {cap_hi_wr, cmp_hi_wr} <= cap ? 2'b10 : 2'b01;
        wr_byte <= v[15:8];
        @(posedge mclk);
        {cap_hi_wr, cmp_hi_wr} <= 2'b00;
    endtask

    task wait_irq(input int lim, output int cnt);
        cnt = 0;
        do begin
            cyc(1);
            cnt++;
        end while (match_interrupt !== 1'b1 && cnt < lim);
        `CHK("interrupt", 1'b1, match_interrupt)
        `CHK("count at match", CNT_ZERO, count_value)
    endtask

    task t_reset();
        `CHK("control", CTRL_RESET, timer_control_reg)
        `CHK("compare", DATA_RESET, compare_value_reg)
        `CHK("capture", DATA_RESET, capture_second_reg)
        `CHK("count", CNT_ZERO, count_value)
        `CHK("interrupt", 1'b0, match_interrupt)
        $display("test reset done");
    endtask

    task t_stage();
        wr_ctrl(8'h08);
        @(posedge mclk);
        cmp_lo_wr <= 1;
        wr_byte <= 8'h05;
        @(posedge mclk);
        cmp_lo_wr <= 0;
        cyc(40);
        `CHK("compare", DATA_RESET, compare_value_reg)
        wr16(0, 16'h0005);
        cyc(12);
        `CHK("compare", 16'h0005, compare_value_reg)
        wr16(1, 16'h1234);
        cyc(20);
        `CHK("capture", DATA_RESET, capture_second_reg)
        $display("test staging done");
    endtask

    task t_timer();
        for (int i = 0; i < 4; i++) begin
            wr_ctrl(timer_control_reg & 8'hCF);
            wr_ctrl(ck[i] & 8'hCF);
            @(posedge mclk);
            prescaler_tap_select <= (i == 1);
            wr_ctrl(ck[i]);
            wait_irq(11000, n);
            wait_irq(11000, n);
            `CHK("period", per[i], n)
            cyc(1);
            `CHK("pulse width", 1'b0, match_interrupt)
        end
        wr_ctrl(8'h08);
        `CHK("count", CNT_ZERO, count_value)
        $display("test timer done");
    endtask

    task t_capture();
        wr_ctrl(8'h08);
        wr_ctrl(8'h58);
        wr16(0, 16'h0014);
        cyc(20);
        `CHK("compare", 16'h0014, compare_value_reg)
        for (int i = 0; i < 4; i++) begin
            prev = count_value;
            k = 0;
            do begin
                cyc(1);
                k++;
            end while (count_value === prev && k < 20);
            `CHK("capture", prev, capture_second_reg)
        end
        $display("test capture done");
    endtask

    task t_stop();
        wr_ctrl(8'h08);
        wr_ctrl(8'h18);
        cyc(30);
        @(posedge mclk);
        stop_mode <= 1;
        cyc(3);
        `CHK("start", START_STOP, timer_control_reg[5:4])
        prev = count_value;
        cyc(30);
        `CHK("count held", prev, count_value)
        @(posedge mclk);
        stop_mode <= 0;
        cyc(30);
        `CHK("count held", prev, count_value)
        wr_ctrl(8'h18);
        cyc(20);
        `CHK("count runs", 1'b1, count_value > prev)
        wr_ctrl(8'h08);
        $display("test stop done");
    endtask

    task t_modes();
        for (int m = 1; m < 4; m++) begin
            wr_ctrl(8'h08 | m[7:0]);
            wr_ctrl(8'h18 | m[7:0]);
            cyc(40);
            `CHK("count idle", CNT_ZERO, count_value)
            if (m == 3) begin
                wr16(1, 16'h0003);
                cyc(12);
                `CHK("capture", 16'h0003, capture_second_reg)
            end
            wr_ctrl(8'h08 | m[7:0]);
        end
        wr_ctrl(8'h08);
        $display("test modes done");
    endtask

    task t_trig0();
        wr_ctrl(8'h28);
        t0 = cycles;
        i_src.level(1, 20);
        i_src.level(0, 20);
        i_src.level(1, 12);
        wait_irq(300, n);
        n = cycles - t0;
        `CHK("delay ok", 1'b1, (n >= 155 && n <= 185))
        cyc(40);
        `CHK("count halted", CNT_ZERO, count_value)
        $display("test trigger start done");
    endtask

    task t_trig1();
        wr_ctrl(8'h08);
        wr_ctrl(8'h68);
        i_src.level(0, 20);
        i_src.level(1, 40);
        i_src.level(0, 12);
        k = 0;
        for (int i = 0; i < 200; i++) begin
            cyc(1);
            k += (match_interrupt === 1'b1);
        end
        `CHK("interrupts", 0, k)
        `CHK("count halted", CNT_ZERO, count_value)
        t0 = cycles;
        i_src.level(1, 12);
        wait_irq(300, n);
        n = cycles - t0;
        `CHK("delay ok", 1'b1, (n >= 155 && n <= 185))
        $display("test trigger stop done");
    endtask

    task t_noise();
        wr_ctrl(8'h08);
        wr_ctrl(8'h38);
        i_src.glitch(0, 4);
        cyc(60);
        `CHK("count idle", CNT_ZERO, count_value)
        @(posedge mclk);
        slow_mode <= 1;
        i_src.glitch(0, 2);
        cyc(8);
        `CHK("count runs", 1'b1, count_value > CNT_ZERO)
        @(posedge mclk);
        slow_mode <= 0;
        wr_ctrl(8'h08);
        $display("test noise done");
    endtask

    // filtered pin rises as the source clock, compare of 3
    task t_ext_clock();
        wr_ctrl(8'h08);
        wr16(0, 16'h0003);
        cyc(12);
        wr_ctrl(8'h0C);
        wr_ctrl(8'h1C);
        for (int i = 0; i < 2; i++) begin
            i_src.level(0, 12);
            i_src.level(1, 12);
        end
        `CHK("pin ticks", 16'h0002, count_value)
        i_src.level(0, 12);
        fork
            i_src.level(1, 12);
            wait_irq(40, n);
        join
        wr_ctrl(8'h0C);
        $display("test external clock done");
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 0;
        cyc(1);
        t_reset();
        t_stage();
        t_timer();
        t_capture();
        t_stop();
        t_modes();
        t_trig0();
        t_trig1();
        t_noise();
        t_ext_clock();
        stop_test();
    end
endmodule // trig_timer_bench
